/* File: design/adm_pkg.sv */
// Package with widths, mode codes and reset values for the converter output path.
package adm_pkg;
   localparam int           SAMPLE_W      = 8;
   localparam logic [7:0]   CODE_RESET    = 8'h00;
   localparam logic [1:0]   PAIR_LAST     = 2'h1;
   localparam logic [1:0]   DECIM_LAST    = 2'h3;
   localparam logic [1:0]   PHASE_RESET   = 2'h0;
   typedef enum logic [1:0]
   {
      ADM_SINGLE   = 2'b00,
      ADM_PAIRED   = 2'b01,
      ADM_DECIMATE = 2'b11
   } adm_mode_t;
endpackage

/* File: design/adm_mode_decode.sv */
// Mode decoder: turns the two static mode pins into the output path mode.
module adm_mode_decode
(
   input  wire logic             demuxOn,
   input  wire logic             rateSelect,
   output adm_pkg::adm_mode_t    mode
);
   always_comb
   begin
      if (!demuxOn)
      begin
         mode = adm_pkg::ADM_SINGLE;
      end
      else if (rateSelect)
      begin
         mode = adm_pkg::ADM_DECIMATE;
      end
      else
      begin
         mode = adm_pkg::ADM_PAIRED;
      end
   end
endmodule

/* File: design/adc_output_demux_overrange.sv */
// Output demultiplexer with data-ready clock and shared overrange flag.
// Function
// - Samples are unsigned offset binary codes.
// - Demux on high enables the demultiplexer.
// - Rate select picks paired or decimate mode.
// - Primary port: eight true/complement bits, LSB first.
// - Secondary port ordered and paired the same.
// - Data changes on data-ready rising edge.
// - Single mode: secondary repeats primary one sample later.
// - Secondary powered down drives both lines high.
// - Paired mode outputs two samples per edge.
// - Paired: secondary older, primary newer sample.
// - Decimate drops every second sample, quarter rate.
// - One differential overrange flag for both ports.
// - Paired/decimate: flag if either port overranged.
// - Single mode: flag follows primary port only.
module adc_output_demux_overrange
#(
   parameter int W = adm_pkg::SAMPLE_W
)
(
   input  wire logic           sys_clk,
   input  wire logic           sys_rst,
   input  wire logic           sampleClock,
   input  wire logic [W-1:0]   sampleCode,
   input  wire logic           sampleOver,
   input  wire logic           demuxOn,
   input  wire logic           rateSelect,
   input  wire logic           secondaryPowerA,
   input  wire logic           secondaryPowerB,
   output logic      [W-1:0]   primaryWordP,
   output logic      [W-1:0]   primaryWordN,
   output logic      [W-1:0]   secondaryWordP,
   output logic      [W-1:0]   secondaryWordN,
   output logic                wordStrobeClockP,
   output logic                wordStrobeClockN,
   output logic                overFlagP,
   output logic                overFlagN
);
   typedef struct packed
   {
      logic [2:0]   clkSync;
      logic [1:0]   pwrA;
      logic [1:0]   pwrB;
      logic [1:0]   demuxSync;
      logic [1:0]   rateSync;
      logic [W-1:0] codeSyncA;
      logic [W-1:0] codeSyncB;
      logic [1:0]   overSync;
      logic [W-1:0] prevCode;
      logic         prevOver;
      logic [W-1:0] keepCode;
      logic         keepOver;
      logic [W-1:0] primary;
      logic [W-1:0] secondary;
      logic         primOver;
      logic         secOver;
      logic         over;
      logic         strobe;
      logic [1:0]   phase;
   } adm_state_t;

   adm_state_t          q;
   adm_state_t          d;
   adm_pkg::adm_mode_t  mode;
   logic                sampleEdge;
   logic                sampleFall;
   logic                secondaryOn;
   logic [W-1:0]        heldCode;
   logic                heldOver;
   logic                pairSend;
   logic                decimSend;
   logic                decimKeep;

   adm_mode_decode u_mode
   (
      .demuxOn    (q.demuxSync[1]),
      .rateSelect (q.rateSync[1]),
      .mode       (mode)
   );

   // Every pin from the converter core and the board crosses into sys_clk
   // through two flip-flops; bit 0 of each synchroniser only feeds bit 1. Code
   // and flag travel through the same depth as the sampling clock, so the word
   // in the second stage when an edge is found is the one launched with it.
   assign heldCode    = q.codeSyncB;
   assign heldOver    = q.overSync[1];
   assign sampleEdge  = q.clkSync[1] & ~q.clkSync[2];
   assign sampleFall  = q.clkSync[2] & ~q.clkSync[1];
   // The secondary drivers are off only when both power pins are low.
   assign secondaryOn = q.pwrA[1] | q.pwrB[1];

   // Position of the current sample inside a paired or decimated group.
   assign pairSend    = q.phase[0] == adm_pkg::PAIR_LAST[0];
   assign decimSend   = q.phase == adm_pkg::DECIM_LAST - 2'h1;
   assign decimKeep   = q.phase == adm_pkg::PHASE_RESET;

   // There is no demux reset input: the phase counter restarts only with
   // sys_rst or, on every sample, in single mode, so a mode change in mid-stream
   // may pair samples from either side of it, and two blocks cannot be aligned
   // except by a common reset or a common return from single mode.
   always_comb
   begin
      d            = q;
      d.clkSync    = {q.clkSync[1:0], sampleClock};
      d.pwrA       = {q.pwrA[0], secondaryPowerA};
      d.pwrB       = {q.pwrB[0], secondaryPowerB};
      d.demuxSync  = {q.demuxSync[0], demuxOn};
      d.rateSync   = {q.rateSync[0], rateSelect};
      d.codeSyncA  = sampleCode;
      d.codeSyncB  = q.codeSyncA;
      d.overSync   = {q.overSync[0], sampleOver};
      if (sampleEdge)
      begin
         d.prevCode = heldCode;
         d.prevOver = heldOver;
         d.phase    = q.phase + 2'h1;
         unique case (mode)
            adm_pkg::ADM_SINGLE:
            begin
               // Every sample reaches the primary port; the secondary port
               // shows the word that the primary port held one sample earlier.
               d.primary   = heldCode;
               d.primOver  = heldOver;
               d.secondary = q.primary;
               d.secOver   = q.primOver;
               d.over      = heldOver;
               d.strobe    = 1'b1;
               d.phase     = adm_pkg::PHASE_RESET;
            end
            adm_pkg::ADM_PAIRED:
            begin
               // The first sample of a pair waits in prevCode; the second one
               // completes the word, so both ports move on one strobe edge.
               if (pairSend)
               begin
                  d.primary   = heldCode;
                  d.secondary = q.prevCode;
                  d.primOver  = heldOver;
                  d.secOver   = q.prevOver;
                  d.over      = heldOver | q.prevOver;
                  d.strobe    = 1'b1;
               end
               else
               begin
                  d.strobe    = 1'b0;
               end
            end
            adm_pkg::ADM_DECIMATE:
            begin
               // Phases 1 and 3 are dropped. Phase 0 is parked in keepCode, so
               // the secondary port itself only moves together with the
               // primary port, on the rising edge of the strobe.
               if (decimSend)
               begin
                  d.primary   = heldCode;
                  d.secondary = q.keepCode;
                  d.primOver  = heldOver;
                  d.secOver   = q.keepOver;
                  d.over      = heldOver | q.keepOver;
                  d.strobe    = 1'b1;
               end
               else if (decimKeep)
               begin
                  d.keepCode  = heldCode;
                  d.keepOver  = heldOver;
                  d.strobe    = 1'b0;
               end
               else
               begin
                  // A dropped sample leaves the strobe where it is.
                  d.strobe    = q.strobe;
               end
            end
            default:
            begin
               d.strobe = 1'b0;
            end
         endcase
      end
      else if (sampleFall && mode == adm_pkg::ADM_SINGLE)
      begin
         // In single-port mode the strobe is low for the second half of each
         // sampling period, so that it can rise again with the next sample.
         d.strobe = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   // Each bit is a true/complement pair driven from one flip-flop, so the two
   // lines of a powered pair can never disagree. A powered-down secondary port pulls
   // both of its lines high, as an idle driver without bias current would.
   for (genvar i = 0; i < W; i++)
   begin : g_pair
      assign primaryWordP[i]   = q.primary[i];
      assign primaryWordN[i]   = ~q.primary[i];
      assign secondaryWordP[i] = secondaryOn ? q.secondary[i] : 1'b1;
      assign secondaryWordN[i] = secondaryOn ? ~q.secondary[i] : 1'b1;
   end

   // The strobe is a plain level from a flip-flop; receivers treat its rising
   // edge as the moment at which both ports and the flag are valid together.
   always_comb
   begin
      wordStrobeClockP = q.strobe;
      wordStrobeClockN = ~q.strobe;
      overFlagP        = q.over;
      overFlagN        = ~q.over;
   end
endmodule

/* File: verification/adm_monitor.sv */
// Port checker for the converter output path.
module adm_monitor
#(
   parameter int W = 8
)
(
   input wire logic         sys_clk,
   input wire logic         sys_rst,
   input wire logic         sampleClock,
   input wire logic         demuxOn,
   input wire logic         rateSelect,
   input wire logic         secondaryPowerA,
   input wire logic         secondaryPowerB,
   input wire logic [W-1:0] primaryWordP,
   input wire logic [W-1:0] primaryWordN,
   input wire logic [W-1:0] secondaryWordP,
   input wire logic [W-1:0] secondaryWordN,
   input wire logic         wordStrobeClockP,
   input wire logic         wordStrobeClockN,
   input wire logic         overFlagP,
   input wire logic         overFlagN
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // The first sample after reset may leave the strobe unchanged in paired
   // mode, so the rate check starts from the second one.
   logic lastClk;
   logic riseSeen;
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         lastClk  <= 1'b0;
         riseSeen <= 1'b0;
      end
      else
      begin
         lastClk <= sampleClock;
         if (sampleClock && !lastClk)
         begin
            riseSeen <= 1'b1;
         end
      end
   end
   sequence s_change; ##[2:5] $changed(wordStrobeClockP); endsequence
   sequence s_off; (!secondaryPowerA && !secondaryPowerB) [*4]; endsequence
   property p_pcomp; primaryWordN == ~primaryWordP; endproperty
   property p_scomp; secondaryPowerA [*4] |-> secondaryWordN == ~secondaryWordP; endproperty
   property p_soff; s_off |-> &secondaryWordP && &secondaryWordN; endproperty
   property p_dcomp; wordStrobeClockN == ~wordStrobeClockP; endproperty
   property p_ocomp; overFlagN == ~overFlagP; endproperty
   property p_rise; $changed(primaryWordP) |-> $rose(wordStrobeClockP); endproperty
   property p_orise; $changed(overFlagP) |-> $rose(wordStrobeClockP); endproperty
   property p_srise;
      riseSeen && $changed(secondaryWordP) |-> $rose(wordStrobeClockP);
   endproperty
   property p_rate;
      riseSeen && $rose(sampleClock) && !(demuxOn && rateSelect) |-> s_change;
   endproperty
   a_pcomp: assert property (p_pcomp) else $error("primary lines not complementary");
   a_scomp: assert property (p_scomp) else $error("secondary lines not complementary");
   a_soff: assert property (p_soff) else $error("powered-down port not high");
   a_dcomp: assert property (p_dcomp) else $error("strobe lines not complementary");
   a_ocomp: assert property (p_ocomp) else $error("flag lines not complementary");
   a_rise: assert property (p_rise) else $error("data changed off strobe rise");
   a_orise: assert property (p_orise) else $error("flag changed off strobe rise");
   a_srise: assert property (p_srise) else $error("secondary changed off strobe rise");
   a_rate: assert property (p_rate) else $error("strobe missed a sample");
endmodule
bind adc_output_demux_overrange adm_monitor #(.W(W)) mon_u (.*);

/* File: verification/adm_capture.sv */
// Receiving capture logic: latches both ports and the flag on each strobe rise.
module adm_capture
(
   input wire logic       sys_clk,
   input wire logic       wordStrobeClockP,
   input wire logic [7:0] primaryWordP,
   input wire logic [7:0] secondaryWordP,
   input wire logic       overFlagP,
   output logic     [16:0] cap,
   output int             n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic last = 1'b0;
   initial n = 0;
   always @(posedge sys_clk)
   begin
      last <= wordStrobeClockP;
      if (wordStrobeClockP && !last)
      begin
         cap <= {overFlagP, secondaryWordP, primaryWordP};
         n <= n + 1;
      end
   end
endmodule

/* File: verification/adc_output_demux_overrange_tb.sv */
// Testbench for the converter output path in all three modes.
module adc_output_demux_overrange_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk = 0, sys_rst = 1, sampleClock = 0, sampleOver = 0;
   logic        demuxOn = 0, rateSelect = 0, secondaryPowerA = 1, secondaryPowerB = 1;
   logic [7:0]  sampleCode = 8'h00, primaryWordP, primaryWordN, secondaryWordP, secondaryWordN;
   logic        wordStrobeClockP, wordStrobeClockN, overFlagP, overFlagN;
   logic [16:0] cap;
   logic [31:0] rnd = 32'h2b9c;
   logic [8:0]  q[$];
   int          n, words, err_total = 0, checks = 0;
   adc_output_demux_overrange dut_u (.*);
   adm_capture cap_u (.*);
   always #25 sys_clk = ~sys_clk;
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      return v ^ (v << 5);
   endfunction
   task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Decimate keeps samples 2 and 0 of each four, counted from reset.
   task automatic expect_word(input int j);
      logic [8:0] a;
      logic [8:0] b;
      logic       hit;
      a = q[j];
      hit = !demuxOn ? 1'b1 : (rateSelect ? j % 4 == 2 : j % 2 == 1);
      b = j == 0 ? 9'h000 : q[rateSelect && demuxOn ? j - 2 : j - 1];
      if (!demuxOn)
         b[8] = 1'b0;
      if (!secondaryPowerA)
         b[7:0] = 8'hff;
      if (hit)
      begin
         words++;
         chk(cap, {a[8] | b[8], b[7:0], a[7:0]});
      end
      chk(17'(n), 17'(words));
   endtask
   task automatic run(input logic d, input logic r, input logic p);
      @(posedge sys_clk);
      sys_rst <= 1;
      demuxOn <= d;
      rateSelect <= r;
      secondaryPowerA <= p;
      secondaryPowerB <= p;
      q = {};
      repeat (20) @(posedge sys_clk);
      sys_rst <= 0;
      words = n;
      for (int k = 0; k <= 24; k++)
      begin
         rnd = xs(rnd);
         sampleClock <= 0;
         {sampleOver, sampleCode} <= rnd[8:0];
         repeat (4) @(posedge sys_clk);
         if (k > 0)
            expect_word(k - 1);
         q.push_back(rnd[8:0]);
         sampleClock <= 1;
         repeat (4) @(posedge sys_clk);
      end
   endtask
   initial
   begin
      run(0, 0, 0);
      run(0, 1, 1);
      run(1, 0, 1);
      run(1, 1, 1);
      end_sim();
   end
   initial
   begin
      #80000;
      err_total++;
      end_sim();
   end
endmodule
